// ==== tb.sv ====
// Self-checking bench of the UART decode trigger.
// Assumes the bound checker and two sender models on the lines.
module tb
  import udt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DV = 8;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, trig_out, next_bus_busy, rx_line, tx_line, er;
  // Sender settings
  logic m_pol = 1'b0;
  logic [1:0] m_par = 2'h0, m_stp = 2'h0;
  logic [3:0] m_nb = 4'h8;
  logic [20:0] m_dv = 21'(DV);
  int failures = 0, compares = 0, tcount = 0;
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  udt_top i_udt_top (.clk_sys(clk_sys), .nrst(nrst), .rx_line(rx_line),
    .tx_line(tx_line), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_out(trig_out), .next_bus_busy(next_bus_busy));
  udt_uart_model i_rxm (.clk_sys(clk_sys), .pol_low(m_pol), .par(m_par), .stop(m_stp),
    .nbits(m_nb), .div(m_dv), .line(rx_line));
  udt_uart_model i_txm (.clk_sys(clk_sys), .pol_low(m_pol), .par(m_par), .stop(m_stp),
    .nbits(m_nb), .div(m_dv), .line(tx_line));
  // Count trigger pulses
  always @(posedge clk_sys) if (trig_out === 1'b1) tcount <= tcount + 1;
  task automatic summarize();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(32'(n < 20), 32'h1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // Control word from sender settings; settles the line afterwards
  task automatic cfg(input logic [2:0] md, input logic [31:0] x);
    wr(A_CTRL, 32'h1 | (32'(m_pol) << C_POL) | (32'(m_par) << C_PAR) | x
      | (32'(m_stp) << C_STOP) | (32'(m_nb) << C_DBITS) | (32'(md) << C_MODE));
    repeat (200) @(posedge clk_sys);
  endtask
  // Send one symbol and compare the trigger count
  task automatic sx(input logic tx, input logic [8:0] d, input logic bp, input logic bs,
      input int gap, input int n);
    int t0;
    t0 = tcount;
    if (tx) i_txm.send(d, bp, bs, gap);
    else i_rxm.send(d, bp, bs, gap);
    repeat (4) @(posedge clk_sys);
    check(32'(tcount - t0), 32'(n));
  endtask
  function automatic logic [8:0] msk(input logic [3:0] n);
    return (9'h1 << n) - 9'h1;
  endfunction
  function automatic int hit(input logic [8:0] d, input logic [8:0] v, input logic [8:0] c);
    return int'(((d ^ v) & c) == 9'h0);
  endfunction
  initial begin
    logic [8:0] d, e;
    void'($urandom(75));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(A_CTRL, CTRL_RST);
    rdc(A_DIV, 32'(DIV_RST));
    rdc(A_IDLE, 32'(IDLE_RST));
    rdc(A_POFF, 32'h0);
    wr(A_TCNT, 32'hFFFF_FFFF);
    rdc(A_TCNT, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, 8'h06, 32'h1);
    check({31'h0, er}, 32'h1);
    // Misaligned write inside the pattern range must not land
    apb(1'b1, 8'h11, 32'h1);
    check({31'h0, er}, 32'h1);
    rdc(A_PAT0, 32'h0);
    wr(A_DIV, 32'(DV));
    wr(A_IDLE, 32'h28);
    for (int k = 0; k < 6; k++) begin
      m_par = 2'(k % 3);
      m_stp = 2'(k % 3);
      m_pol = k[0];
      m_nb = 4'(5 + $urandom % 5);
      d = 9'($urandom);
      e = 9'($urandom);
      cfg(UDT_T_START, 32'h0);
      sx(1'b0, d, 1'b0, 1'b0, 60, 1);
      wr(A_PAT0, {7'h0, msk(m_nb), 7'h0, d});
      cfg(UDT_T_ANY, 32'h0);
      sx(1'b0, d, 1'b0, 1'b0, 60, 1);
      sx(1'b0, e, 1'b0, 1'b0, 60, hit(e, d, msk(m_nb)));
      cfg(UDT_T_FERR, 32'h0);
      sx(1'b0, d, 1'b0, 1'b1, 60, 1);
      sx(1'b0, d, 1'b0, 1'b0, 60, 0);
      if (m_par != 2'h0) begin
        cfg(UDT_T_PERR, 32'h0);
        sx(1'b0, d, 1'b1, 1'b0, 60, 1);
        sx(1'b0, e, 1'b0, 1'b0, 60, 0);
      end
    end
    m_par = 2'h0;
    m_stp = 2'h0;
    m_pol = 1'b0;
    m_nb = 4'h8;
    cfg(UDT_T_FSTART, 32'h0);
    sx(1'b0, 9'h012, 1'b0, 1'b0, 60, 1);
    sx(1'b0, 9'h034, 1'b0, 1'b0, 10, 0);
    sx(1'b0, 9'h056, 1'b0, 1'b0, 60, 1);
    cfg(UDT_T_BRK, 32'h0);
    sx(1'b0, 9'h000, 1'b0, 1'b1, 60, 1);
    sx(1'b0, 9'h080, 1'b0, 1'b1, 60, 0);
    wr(A_POFF, 32'h2);
    cfg(UDT_T_SYMN, 32'h0);
    sx(1'b0, 9'h011, 1'b0, 1'b0, 60, 0);
    sx(1'b0, 9'h022, 1'b0, 1'b0, 10, 0);
    sx(1'b0, 9'h033, 1'b0, 1'b0, 10, 1);
    wr(A_POFF, 32'h1);
    wr(A_PAT0, 32'h00FF_00A5);
    wr(A_PAT1, 32'h00F0_003C);
    cfg(UDT_T_PAT, 32'h1 << C_PLEN);
    sx(1'b0, 9'h011, 1'b0, 1'b0, 60, 0);
    sx(1'b0, 9'h0A5, 1'b0, 1'b0, 10, 0);
    sx(1'b0, 9'h037, 1'b0, 1'b0, 10, 1);
    sx(1'b0, 9'h0A5, 1'b0, 1'b0, 60, 0);
    sx(1'b0, 9'h03C, 1'b0, 1'b0, 10, 0);
    // Preset entry seven, 1 MBit/s, is 200 cycles per bit
    m_dv = 21'h0C8;
    wr(A_PAT0, 32'h00FF_005A);
    cfg(UDT_T_ANY, (32'h1 << C_PRE) | (32'h7 << C_RIDX));
    sx(1'b0, 9'h05A, 1'b0, 1'b0, 60, 1);
    sx(1'b0, 9'h0A5, 1'b0, 1'b0, 60, 0);
    m_dv = 21'(DV);
    m_pol = 1'b1;
    cfg(UDT_T_START, (32'h1 << C_TXEN) | (32'h1 << C_SRC));
    apb(1'b0, A_STAT, 32'h0);
    check(32'(rd[S_TXOK]), 32'h1);
    check(32'(rd[S_TRIG]), 32'h1);
    check(32'(next_bus_busy), 32'h1);
    sx(1'b1, 9'h05A, 1'b0, 1'b0, 60, 1);
    sx(1'b0, 9'h05A, 1'b0, 1'b0, 60, 0);
    cfg(UDT_T_START, (32'h1 << C_TXEN) | (32'h1 << C_SRC) | (32'h1 << C_BUS));
    apb(1'b0, A_STAT, 32'h0);
    check(32'(next_bus_busy), 32'h0);
    // Write one clears the sticky trigger flag
    wr(A_STAT, 32'h1 << S_TRIG);
    apb(1'b0, A_STAT, 32'h0);
    check(32'(rd[S_TRIG]), 32'h0);
    sx(1'b0, 9'h0C3, 1'b0, 1'b0, 60, 1);
    rdc(A_TCNT, 32'(tcount));
    summarize();
  end
  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule // tb

// ==== udt_pkg.sv ====
// Shared constants, fields and types of the UART decode trigger.
// Assumes a single 200 MHz sampling clock and an APB register port.
package udt_pkg;
  // Sampling clock rate in Hz
  localparam int CLK_HZ = 200_000_000;
  // User bit-rate limits in bit/s
  localparam int RATE_MIN = 150;
  localparam int RATE_MAX = 39_062_500;
  // Bit divisor limits, clock cycles per bit
  localparam logic [20:0] DIV_MIN = 21'(CLK_HZ / RATE_MAX);
  localparam logic [20:0] DIV_MAX = 21'(CLK_HZ / RATE_MIN);
  // Data size limits
  localparam logic [3:0] DBITS_MIN = 4'h5;
  localparam logic [3:0] DBITS_MAX = 4'h9;
  // Widths of idle count, offset, symbol index, symbol
  localparam int IDLE_W = 24;
  localparam int POFF_W = 12;
  localparam int SIDX_W = 13;
  localparam int SYM_W = 9;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV = 8'h04;
  localparam logic [7:0] A_IDLE = 8'h08;
  localparam logic [7:0] A_POFF = 8'h0C;
  localparam logic [7:0] A_PAT0 = 8'h10;
  localparam logic [7:0] A_PAT1 = 8'h14;
  localparam logic [7:0] A_PAT2 = 8'h18;
  localparam logic [7:0] A_PAT3 = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_TCNT = 8'h24;
  // Control register fields
  localparam int C_EN = 0;
  localparam int C_POL = 1;
  localparam int C_PAR = 2;
  localparam int C_STOP = 4;
  localparam int C_DBITS = 6;
  localparam int C_TXEN = 10;
  localparam int C_SRC = 11;
  localparam int C_BUS = 12;
  localparam int C_PRE = 14;
  localparam int C_RIDX = 15;
  localparam int C_MODE = 18;
  localparam int C_PLEN = 21;
  // Pattern register: value low, care mask high
  localparam int P_MASK = 16;
  // Status register fields
  localparam int S_TRIG = 0;
  localparam int S_TXOK = 1;
  localparam int S_SIDX = 4;
  localparam int S_LAST = 20;
  // Reset values: 8 data bits, 9600 bit/s, 1 ms idle
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  localparam logic [20:0] DIV_RST = 21'(CLK_HZ / 9600);
  localparam logic [23:0] IDLE_RST = 24'(CLK_HZ / 1000);
  // Parity choices
  typedef enum logic [1:0] {
    UDT_PAR_NONE = 2'h0, UDT_PAR_EVEN = 2'h1, UDT_PAR_ODD = 2'h2
  } udt_par_t;
  // Stop lengths
  typedef enum logic [1:0] {
    UDT_STOP_1 = 2'h0, UDT_STOP_15 = 2'h1, UDT_STOP_2 = 2'h2
  } udt_stop_t;
  // Trigger conditions
  typedef enum logic [2:0] {
    UDT_T_START = 3'h0, UDT_T_FSTART = 3'h1, UDT_T_FERR = 3'h2,
    UDT_T_SYMN = 3'h3, UDT_T_BRK = 3'h4, UDT_T_PERR = 3'h5,
    UDT_T_PAT = 3'h6, UDT_T_ANY = 3'h7
  } udt_mode_t;
  // Receiver states, Gray along the symbol path
  typedef enum logic [2:0] {
    UDT_IDLE = 3'h0, UDT_START = 3'h1, UDT_DATA = 3'h3,
    UDT_PARB = 3'h2, UDT_STOP = 3'h6, UDT_XSTOP = 3'h7
  } udt_st_t;
  // Divisor of a predefined rate
  function automatic logic [20:0] udt_rate_div(input logic [2:0] idx);
    case (idx)
      3'h0: return 21'(CLK_HZ / 300);
      3'h1: return 21'(CLK_HZ / 1200);
      3'h2: return 21'(CLK_HZ / 2400);
      3'h3: return 21'(CLK_HZ / 9600);
      3'h4: return 21'(CLK_HZ / 19200);
      3'h5: return 21'(CLK_HZ / 57600);
      3'h6: return 21'(CLK_HZ / 115200);
      default: return 21'(CLK_HZ / 1_000_000);
    endcase
  endfunction
endpackage

// ==== udt_rx.sv ====
// One-line symbol receiver with oversampled bit timing.
// Assumes an asynchronous line input and settings from the same clock.
module udt_rx
  import udt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic line_in,
  input wire logic enable,
  input wire logic pol_low,
  input wire logic [20:0] div,
  input wire logic [20:0] xstop,
  input wire logic [3:0] nbits,
  input wire logic [1:0] par,
  input wire logic [IDLE_W-1:0] idle_thr,
  output logic start_p,
  output logic fstart_p,
  output logic sym_p,
  output logic [SYM_W-1:0] sym_data,
  output logic par_err,
  output logic frm_err,
  output logic brk
);
  logic s1_r, s2_r, lq_r, pb_r, gok_r;
  udt_st_t st_r;
  logic [20:0] cnt_r;
  logic [3:0] bit_r;
  logic [SYM_W-1:0] sh_r;
  logic [IDLE_W-1:0] gap_r;
  // Logic level after polarity; start edge; bit centre
  // [RULE_06] polarity picks the one level
  wire lvl = s2_r ^ pol_low;
  wire fall = lq_r & ~lvl;
  wire tick = (cnt_r == 21'h0);
  wire [20:0] half = div >> 1;
  wire odd = ^sh_r ^ pb_r;
  wire perr = (par == UDT_PAR_EVEN) ? odd : (par == UDT_PAR_ODD) & ~odd;
  // Line synchroniser; first flop feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= line_in;
      s2_r <= s1_r;
    end
  end
  // Symbol sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= UDT_IDLE;
      lq_r <= 1'b1;
      cnt_r <= 21'h0;
      bit_r <= 4'h0;
      sh_r <= '0;
      pb_r <= 1'b0;
      gap_r <= '1;
      gok_r <= 1'b0;
      {start_p, fstart_p, sym_p, par_err, frm_err, brk} <= 6'h00;
      sym_data <= '0;
    end else begin
      lq_r <= lvl;
      {start_p, fstart_p, sym_p} <= 3'h0;
      cnt_r <= tick ? cnt_r : cnt_r - 21'h1;
      // Idle gap counts from the return to idle, half a bit before the last stop bit ends
      if (st_r == UDT_IDLE && lvl && gap_r != '1)
        gap_r <= gap_r + IDLE_W'(1);
      if (!enable) begin
        st_r <= UDT_IDLE;
      // [RULE_23] resync on start edge
      end else if (fall && (st_r == UDT_IDLE || st_r == UDT_XSTOP)) begin
        st_r <= UDT_START;
        cnt_r <= half;
        // [RULE_13] gap measured here
        gok_r <= (gap_r >= idle_thr);
        gap_r <= '0;
      end else begin
        case (st_r)
          UDT_START: if (tick) begin
            // [RULE_02] start must read zero
            if (!lvl) begin
              st_r <= UDT_DATA;
              start_p <= 1'b1;
              fstart_p <= gok_r;
              cnt_r <= div - 21'h1;
              bit_r <= 4'h0;
              sh_r <= '0;
              pb_r <= 1'b0;
            end else begin
              st_r <= UDT_IDLE;
            end
          end
          UDT_DATA: if (tick) begin
            // [RULE_12] data bits LSB first
            sh_r[bit_r] <= lvl;
            bit_r <= bit_r + 4'h1;
            cnt_r <= div - 21'h1;
            if (bit_r == nbits - 4'h1)
              st_r <= (par == UDT_PAR_NONE) ? UDT_STOP : UDT_PARB;
          end
          UDT_PARB: if (tick) begin
            pb_r <= lvl;
            cnt_r <= div - 21'h1;
            st_r <= UDT_STOP;
          end
          UDT_STOP: if (tick) begin
            // [RULE_03] stop must read one
            sym_p <= 1'b1;
            sym_data <= sh_r;
            // [RULE_08] [RULE_09] parity check
            par_err <= perr;
            frm_err <= ~lvl;
            // [RULE_16] line low through the stop
            brk <= ~lvl & (sh_r == '0) & ~pb_r;
            // [RULE_10] extra half or whole stop bit
            cnt_r <= xstop;
            st_r <= (lvl && xstop != 21'h0) ? UDT_XSTOP : UDT_IDLE;
          end
          UDT_XSTOP: if (tick) st_r <= UDT_IDLE;
          default: st_r <= UDT_IDLE;
        endcase
      end
    end
  end
endmodule // udt_rx

// ==== udt_top.sv ====
// UART decode trigger: receive and transmit line decoders,
// trigger conditions, pattern matcher and APB register file.
// Assumes lines are asynchronous and APB runs on clk_sys.
//
// Notes on behaviour
// [RULE_01] Symbol: start, data, optional parity, stops
// [RULE_02] Start bit is logic zero
// [RULE_03] Stop bits and idle are logic one
// [RULE_04] Symbols group into frames split by pauses
// [RULE_05] No line clock; timing from configured rate
// [RULE_06] Polarity selects which level means one
// [RULE_07] One polarity serves both lines
// [RULE_08] Even parity: total ones even
// [RULE_09] Odd parity: total ones odd; none: absent
// [RULE_10] Stop length one, one and half, two
// [RULE_11] Preset rates from 300 or user rate
// [RULE_12] Data size five to nine bits
// [RULE_13] Idle time is minimum gap between frames
// [RULE_14] Transmit line only on bus one, three
// [RULE_15] Trigger on start bit or frame start
// [RULE_16] Break: start not followed by stop
// [RULE_17] Parity error and frame error triggers
// [RULE_18] Pattern of one to four symbols at offset
// [RULE_19] Any-symbol trigger matches one symbol anywhere
// [RULE_20] Offset zero to 4095 symbols into frame
// [RULE_21] Pattern bits zero, one or don't care
// [RULE_22] Source selects receive or transmit line
// [RULE_23] Oversample, resync on start, sample centre
module udt_top
  import udt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic trig_out,
  output logic next_bus_busy
);
  // Register storage
  logic [31:0] ctrl_r;
  logic [20:0] div_r;
  logic [IDLE_W-1:0] idle_r;
  logic [POFF_W-1:0] poff_r;
  logic [31:0] pat_r [4];
  logic trig_st_r;
  logic [31:0] tcnt_r;
  // Frame tracking
  logic [SIDX_W-1:0] sidx_r;
  logic first_r;
  logic ok_r;
  logic [SYM_W-1:0] last_r;
  // Read data before registering
  logic [31:0] rdata;

  // Mask match of one symbol; mask zero bits are don't care
  function automatic logic sym_match(input logic [SYM_W-1:0] s,
                                     input logic [31:0] p);
    return ((s ^ p[SYM_W-1:0]) & p[P_MASK +: SYM_W]) == '0;
  endfunction

  // Control field decode
  wire en = ctrl_r[C_EN];
  wire pol_low = ctrl_r[C_POL];
  wire [1:0] par = ctrl_r[C_PAR +: 2];
  wire [1:0] stop = ctrl_r[C_STOP +: 2];
  wire [3:0] dbits_raw = ctrl_r[C_DBITS +: 4];
  wire [1:0] bus_ch = ctrl_r[C_BUS +: 2];
  wire [2:0] mode = ctrl_r[C_MODE +: 3];
  wire [2:0] plen = {1'b0, ctrl_r[C_PLEN +: 2]} + 3'h1;

  // Data size held within five to nine
  wire [3:0] nbits = (dbits_raw < DBITS_MIN) ? DBITS_MIN :
                     (dbits_raw > DBITS_MAX) ? DBITS_MAX : dbits_raw;

  // [RULE_11] preset table or clamped user rate
  wire [20:0] div_pre = udt_rate_div(ctrl_r[C_RIDX +: 3]);
  wire [20:0] div_usr = (div_r < DIV_MIN) ? DIV_MIN :
                        (div_r > DIV_MAX) ? DIV_MAX : div_r;
  wire [20:0] div = ctrl_r[C_PRE] ? div_pre : div_usr;

  // [RULE_10] extra stop time after the first stop centre
  wire [20:0] xstop = (stop == UDT_STOP_15) ? (div >> 1) :
                      (stop == UDT_STOP_2) ? div : 21'h0;

  // [RULE_14] transmit line only on bus one or three
  wire tx_ok = ctrl_r[C_TXEN] & ~bus_ch[0];
  // [RULE_22] source follows granted transmit line
  wire use_tx = ctrl_r[C_SRC] & tx_ok;

  // Decoder outputs per line
  wire r_start, r_fst, r_sym, r_perr, r_ferr, r_brk;
  wire t_start, t_fst, t_sym, t_perr, t_ferr, t_brk;
  wire [SYM_W-1:0] r_data;
  wire [SYM_W-1:0] t_data;

  // Receive line decoder
  // [RULE_05] timed from configured divisor
  udt_rx u_rx (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .line_in(rx_line),
    .enable(en),
    .pol_low(pol_low),
    .div(div),
    .xstop(xstop),
    .nbits(nbits),
    .par(par),
    .idle_thr(idle_r),
    .start_p(r_start),
    .fstart_p(r_fst),
    .sym_p(r_sym),
    .sym_data(r_data),
    .par_err(r_perr),
    .frm_err(r_ferr),
    .brk(r_brk)
  );

  // Transmit line decoder
  // [RULE_07] same polarity on both lines
  udt_rx u_tx (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .line_in(tx_line),
    .enable(en & tx_ok),
    .pol_low(pol_low),
    .div(div),
    .xstop(xstop),
    .nbits(nbits),
    .par(par),
    .idle_thr(idle_r),
    .start_p(t_start),
    .fstart_p(t_fst),
    .sym_p(t_sym),
    .sym_data(t_data),
    .par_err(t_perr),
    .frm_err(t_ferr),
    .brk(t_brk)
  );

  // Selected source events
  wire s_start = use_tx ? t_start : r_start;
  wire s_fst = use_tx ? t_fst : r_fst;
  wire s_sym = use_tx ? t_sym : r_sym;
  wire [SYM_W-1:0] s_data = use_tx ? t_data : r_data;
  wire s_perr = use_tx ? t_perr : r_perr;
  wire s_ferr = use_tx ? t_ferr : r_ferr;
  wire s_brk = use_tx ? t_brk : r_brk;

  // [RULE_04] first symbol after a pause restarts the index
  wire [SIDX_W-1:0] cur = first_r ? '0 :
                          (sidx_r == '1) ? sidx_r : sidx_r + SIDX_W'(1);
  // [RULE_20] position relative to the offset
  wire [SIDX_W-1:0] poff_x = SIDX_W'(poff_r);
  wire in_win = (cur >= poff_x);
  wire [SIDX_W-1:0] k = cur - poff_x;
  wire k_ok = in_win & (k < SIDX_W'(plen));
  wire [1:0] ki = k[1:0];
  // [RULE_21] masked compare of the current symbol
  wire k_hit = sym_match(s_data, pat_r[ki]);
  wire run_ok = (ki == 2'h0) ? k_hit : (ok_r & k_hit);
  wire k_last = (k == SIDX_W'(plen) - SIDX_W'(1));

  // Trigger conditions of the selected mode
  logic fire;
  always_comb begin
    case (mode)
      // [RULE_15] start bit or frame start
      UDT_T_START: fire = s_start;
      UDT_T_FSTART: fire = s_fst;
      // [RULE_17] frame error and parity error
      UDT_T_FERR: fire = s_sym & s_ferr;
      UDT_T_PERR: fire = s_sym & s_perr;
      // Symbol at the offset position
      UDT_T_SYMN: fire = s_sym & (cur == poff_x);
      // [RULE_16] break condition
      UDT_T_BRK: fire = s_sym & s_brk;
      // [RULE_18] pattern complete at its last symbol
      UDT_T_PAT: fire = s_sym & k_ok & k_last & run_ok;
      // [RULE_19] one symbol anywhere
      UDT_T_ANY: fire = s_sym & sym_match(s_data, pat_r[0]);
      default: fire = 1'b0;
    endcase
  end

  // APB decode
  wire setup = psel & ~penable;
  // Refused addresses never reach a register, misaligned ones too
  wire hit = (paddr[1:0] == 2'h0) && (paddr <= A_TCNT);
  wire wr = psel & penable & pwrite & pready & hit;
  wire w_ctrl = wr & (paddr == A_CTRL);
  wire w_div = wr & (paddr == A_DIV);
  wire w_idle = wr & (paddr == A_IDLE);
  wire w_poff = wr & (paddr == A_POFF);
  wire w_pat = wr & (paddr[7:4] == A_PAT0[7:4]);
  wire w_stat = wr & (paddr == A_STAT);
  wire [1:0] pidx = paddr[3:2];

  // Read multiplexer; unused bits read zero, but control and pattern words read back all 32 written bits
  always_comb begin
    rdata = 32'h0;
    case (paddr)
      A_CTRL: rdata = ctrl_r;
      A_DIV: rdata = 32'(div_r);
      A_IDLE: rdata = 32'(idle_r);
      A_POFF: rdata = 32'(poff_r);
      A_PAT0, A_PAT1, A_PAT2, A_PAT3: rdata = pat_r[pidx];
      A_STAT: begin
        rdata[S_TRIG] = trig_st_r;
        rdata[S_TXOK] = tx_ok;
        rdata[S_SIDX +: SIDX_W] = sidx_r;
        rdata[S_LAST +: SYM_W] = last_r;
      end
      A_TCNT: rdata = tcnt_r;
      default: rdata = 32'h0;
    endcase
  end

  // APB answer: ready in the first access cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      // Read data captured for the access phase
      if (setup)
        prdata <= (hit && !pwrite) ? rdata : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RST;
      div_r <= DIV_RST;
      idle_r <= IDLE_RST;
      poff_r <= '0;
    end else begin
      if (w_ctrl)
        ctrl_r <= pwdata;
      if (w_div)
        div_r <= pwdata[20:0];
      // [RULE_13] idle threshold in clock cycles
      if (w_idle)
        idle_r <= pwdata[IDLE_W-1:0];
      if (w_poff)
        poff_r <= pwdata[POFF_W-1:0];
    end
  end

  // Pattern registers: value and care mask
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++)
        pat_r[i] <= 32'h0;
    end else if (w_pat) begin
      pat_r[pidx] <= pwdata;
    end
  end

  // Frame position and pattern progress
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sidx_r <= '0;
      first_r <= 1'b1;
      ok_r <= 1'b0;
      last_r <= '0;
    end else if (!en) begin
      first_r <= 1'b1;
      ok_r <= 1'b0;
    // [RULE_04] frame start re-arms the index
    end else if (s_fst) begin
      first_r <= 1'b1;
    end else if (s_sym) begin
      sidx_r <= cur;
      first_r <= 1'b0;
      last_r <= s_data;
      ok_r <= k_ok & run_ok;
    end
  end

  // Trigger output, sticky flag and counter
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      trig_out <= 1'b0;
      trig_st_r <= 1'b0;
      tcnt_r <= 32'h0;
      next_bus_busy <= 1'b0;
    end else begin
      trig_out <= en & fire;
      // [RULE_14] following bus taken by transmit line
      next_bus_busy <= tx_ok;
      // New trigger wins over a write-one clear
      if (en & fire)
        trig_st_r <= 1'b1;
      else if (w_stat && pwdata[S_TRIG])
        trig_st_r <= 1'b0;
      if (en & fire)
        tcnt_r <= tcnt_r + 32'h1;
    end
  end
endmodule // udt_top

// ==== udt_top_assertions.sv ====
// Port checker for the UART decode trigger top.
// Assumes one clock clk_sys and a synchronous active-low nrst.
module udt_top_chk
  import udt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trig_out,
  input wire logic next_bus_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Write accepted by the slave
  wire logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  // Address off the map or misaligned
  wire logic bad_a;
  assign bad_a = (paddr > A_TCNT) || (paddr[1:0] != 2'h0);
  // Setup cycle of a transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // Completing access cycle
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel && !penable) && penable)
    else $error("pready without setup");
  a_err_unmapped: assert property (s_done ##0 bad_a |-> pslverr)
    else $error("unmapped access not refused");
  a_err_only_bad: assert property (pslverr |-> pready && bad_a)
    else $error("error on mapped access");
  a_rd_unmapped: assert property (s_done ##0 (bad_a && !pwrite) |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_setup: assert property ($changed(prdata) && $past(nrst) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_trig_pulse: assert property (trig_out |=> !trig_out)
    else $error("trigger longer than one cycle");
  a_busy_by_write: assert property ($changed(next_bus_busy) && $past(nrst) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("channel claim changed without write");
endmodule // udt_top_chk

bind udt_top udt_top_chk i_udt_top_chk (
  .clk_sys(clk_sys), .nrst(nrst), .rx_line(rx_line), .tx_line(tx_line), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trig_out(trig_out), .next_bus_busy(next_bus_busy));

// ==== udt_uart_model.sv ====
// Behavioural asynchronous serial sender driving one line.
// Assumes send is called right after a rising clk_sys edge.
module udt_uart_model
  import udt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic pol_low,
  input wire logic [1:0] par,
  input wire logic [1:0] stop,
  input wire logic [3:0] nbits,
  input wire logic [20:0] div,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Logical level before polarity
  logic lvl = 1'b1;
  assign line = lvl ^ pol_low;
  // Hold one level for n cycles
  task automatic hold(input logic v, input int n);
    lvl <= v;
    repeat (n) @(posedge clk_sys);
  endtask
  // One symbol; bp flips parity, bs drops the stop bit
  task automatic send(input logic [8:0] d, input logic bp, input logic bs, input int gap);
    logic [8:0] m;
    m = d & ((9'h1 << nbits) - 9'h1);
    hold(1'b1, gap);
    hold(1'b0, int'(div));
    for (int i = 0; i < nbits; i++) hold(m[i], int'(div));
    if (par != 2'h0) hold((^m) ^ (par == 2'h2) ^ bp, int'(div));
    hold(!bs, (stop == 2'h0) ? div : (stop == 2'h1) ? div * 3 / 2 : div * 2);
    hold(1'b1, int'(div) * 2);
  endtask
endmodule // udt_uart_model
